// [fpdu_pkg.sv]
// fpdu_pkg.sv: constants, types and helpers of the fixed-point divide unit
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package fpdu_pkg;

  // ****************************************
  // instruction fields (bit 0 is the lsb of the word)
  // ****************************************
  localparam logic [5:0] PRIMARY_OP = 6'h1F;
  localparam logic [8:0] XO_SDIV    = 9'h1E9;
  localparam logic [8:0] XO_UDIV    = 9'h1C9;
  localparam logic [8:0] XO_SHORT   = 9'h16B;
  localparam int         PO_HI      = 31;
  localparam int         PO_LO      = 26;
  localparam int         XO_HI      = 9;
  localparam int         XO_LO      = 1;
  localparam int         OE_BIT     = 10;
  localparam int         RC_BIT     = 0;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_INSTR    = 8'h00;
  localparam logic [7:0] ADDR_DVD_LO   = 8'h04;
  localparam logic [7:0] ADDR_DVD_HI   = 8'h08;
  localparam logic [7:0] ADDR_DVS_LO   = 8'h0C;
  localparam logic [7:0] ADDR_DVS_HI   = 8'h10;
  localparam logic [7:0] ADDR_RES_LO   = 8'h14;
  localparam logic [7:0] ADDR_RES_HI   = 8'h18;
  localparam logic [7:0] ADDR_EXT      = 8'h1C;
  localparam logic [7:0] ADDR_XER      = 8'h20;
  localparam logic [7:0] ADDR_CR0      = 8'h24;
  localparam logic [7:0] ADDR_STATUS   = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;

  // ****************************************
  // field positions, reset values and divide constants
  // ****************************************
  localparam int XER_SO   = 2;
  localparam int XER_OV   = 1;
  localparam int XER_CA   = 0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ILL  = 1;
  localparam int IRQ_OVF  = 2;
  localparam logic [2:0]  XER_RST  = 3'h0;
  localparam logic [3:0]  CR0_RST  = 4'h0;
  localparam logic [2:0]  IRQ_RST  = 3'h0;
  localparam logic [63:0] MIN64    = 64'h8000000000000000;
  localparam logic [63:0] ONES64   = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [31:0] MIN32    = 32'h80000000;
  localparam logic [6:0]  DIV_LAST = 7'h3F;

  // ****************************************
  // types and helpers
  // ****************************************
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_SDIV  = 2'b01,
    OP_UDIV  = 2'b10,
    OP_SHORT = 2'b11
  } fpdu_op_t;

  function automatic fpdu_op_t fpdu_decode(logic [31:0] w);
    fpdu_op_t op;
    op = OP_NONE;
    if (w[PO_HI:PO_LO] == PRIMARY_OP) begin
      if (w[XO_HI:XO_LO] == XO_SDIV) op = OP_SDIV;
      else if (w[XO_HI:XO_LO] == XO_UDIV) op = OP_UDIV;
      else if (w[XO_HI:XO_LO] == XO_SHORT) op = OP_SHORT;
    end
    return op;
  endfunction : fpdu_decode

  function automatic logic [63:0] fpdu_sext32(logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction : fpdu_sext32

endpackage : fpdu_pkg
`default_nettype wire

// [fpdu_div_if.sv]
// fpdu_div_if.sv: link between the divide front end and the iterative core
// assumes both ends share pclk
`default_nettype none
interface fpdu_div_if;
  logic        start;
  logic [63:0] dividend;
  logic [63:0] divisor;
  logic        done;
  logic [63:0] quotient;
  logic [63:0] remainder;
  modport ctl  (output start, dividend, divisor, input done, quotient, remainder);
  modport core (input start, dividend, divisor, output done, quotient, remainder);
endinterface : fpdu_div_if
`default_nettype wire

// [fpdu_divcore.sv]
// fpdu_divcore.sv: unsigned 64-bit restoring divider, one quotient bit per cycle
// assumes start is a one-cycle pulse taken only while idle
`default_nettype none
module fpdu_divcore
  import fpdu_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request and answer
  fpdu_div_if.core dif
);

  typedef enum logic {CORE_IDLE = 1'b0, CORE_RUN = 1'b1} fpdu_core_state_t;

  fpdu_core_state_t state_reg, state_next;
  logic [6:0]       cnt_reg,   cnt_next;
  logic [63:0]      rem_reg,   rem_next;
  logic [63:0]      quo_reg,   quo_next;
  logic [63:0]      dvs_reg,   dvs_next;
  logic             done_reg,  done_next;
  logic [64:0]      shifted;
  logic [64:0]      diff;

  always_comb begin
    shifted    = {rem_reg, quo_reg[63]};
    diff       = shifted - {1'b0, dvs_reg};
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rem_next   = rem_reg;
    quo_next   = quo_reg;
    dvs_next   = dvs_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      CORE_IDLE: if (dif.start) begin
        state_next = CORE_RUN;
        cnt_next   = 7'h00;
        rem_next   = 64'h0;
        quo_next   = dif.dividend;
        dvs_next   = dif.divisor;
      end
      CORE_RUN: begin
        // subtract only when the shifted remainder covers the divisor
        quo_next = {quo_reg[62:0], ~diff[64]};
        rem_next = diff[64] ? shifted[63:0] : diff[63:0];
        cnt_next = cnt_reg + 7'h01;
        if (cnt_reg == DIV_LAST) begin
          state_next = CORE_IDLE;
          done_next  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CORE_IDLE;
      cnt_reg   <= 7'h00;
      rem_reg   <= 64'h0;
      quo_reg   <= 64'h0;
      dvs_reg   <= 64'h0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      rem_reg   <= rem_next;
      quo_reg   <= quo_next;
      dvs_reg   <= dvs_next;
      done_reg  <= done_next;
    end
  end

  assign dif.done      = done_reg;
  assign dif.quotient  = quo_reg;
  assign dif.remainder = rem_reg;

  a_core_quot: assert property (@(posedge pclk) disable iff (!presetn)
    (dif.start && state_reg == CORE_IDLE && dif.divisor != 64'h0) |-> ##65
    (dif.done && dif.quotient == $past(dif.dividend, 65) / $past(dif.divisor, 65)))
    else $error("core quotient wrong or late");

endmodule : fpdu_divcore
`default_nettype wire

// [fpdu_top.sv]
// fpdu_top.sv: fixed-point divide unit with APB registers and interrupt
// assumes an APB master on pclk; operands are loaded before the opcode word
//
// Notes on behaviour
// - opcode 31, extended 489 is signed doubleword divide; bit 21 trap, 31 record.
// - opcode 31, extended 457 is unsigned doubleword divide, same trap/record bits.
// - opcode 31, extended 363 is short divide with four trap/record forms.
// - signed doubleword divide writes 64-bit quotient only, no remainder.
// - signed quotient truncates toward zero.
// - signed min/-1 or divide by zero: result undefined, trap enable sets excess.
// - unsigned doubleword divide treats operands and quotient as unsigned.
// - unsigned divide record sets condition bits by signed compare with zero.
// - unsigned divide by zero: result undefined, trap enable sets excess.
// - condition field only with record set; exception flags only with trap set.
// - exception flags reflect full 64-bit overflow in every mode; short divide flags the word min/-1 case instead.
// - without 64-bit support doubleword divides raise illegal instruction.
// - short divide writes quotient and remainder; remainder takes dividend sign.
// - short min/-1 gives extension zero and result min word.
// - short divide never changes the carry flag.
// - short divide updates sticky and excess flags only when trap enabled.
// - short divide with record updates the condition field from the result; here min/-1 sets it from the +2**31 quotient instead.
//
// Design decisions made here: the register addresses and register access over APB.
`default_nettype none
module fpdu_top
  import fpdu_pkg::*;
#(
  parameter bit IMPL64 = 1'b1
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // interrupt
  output var  logic        irq
);

  typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} fpdu_state_t;

  // ****************************************
  // state
  // ****************************************
  logic [31:0] prdata_reg,  prdata_next;
  logic        pready_reg,  pready_next;
  logic        pslverr_reg, pslverr_next;
  fpdu_state_t state_reg,   state_next;
  fpdu_op_t    op_reg,      op_next;
  logic        oe_reg,      oe_next;
  logic        rc_reg,      rc_next;
  logic        go_reg,      go_next;
  logic [31:0] instr_reg,   instr_next;
  logic [63:0] dvd_reg,     dvd_next;
  logic [63:0] dvs_reg,     dvs_next;
  logic [63:0] opa_reg,     opa_next;
  logic [63:0] opb_reg,     opb_next;
  logic [63:0] res_reg,     res_next;
  logic [31:0] ext_reg,     ext_next;
  logic [2:0]  xer_reg,     xer_next;
  logic [3:0]  cr0_reg,     cr0_next;
  logic [2:0]  stat_reg,    stat_next;
  logic [2:0]  mask_reg,    mask_next;
  logic        irq_reg,     irq_next;

  logic        access;
  logic        wr;
  logic        xer_wr;
  logic        start_acc;
  logic        fin;
  logic        ovf;
  logic        short_min;
  logic        signed_op;
  logic        neg_q;
  logic        neg_r;
  logic [63:0] q_res;
  logic [63:0] r_res;
  logic [2:0]  irq_set;
  logic [2:0]  w1c;
  fpdu_op_t    dec;

  fpdu_div_if dif ();

  fpdu_divcore u_core (
    .pclk    (pclk),
    .presetn (presetn),
    .dif     (dif)
  );

  // ****************************************
  // operand preparation and sign fix-up
  // ****************************************
  assign access    = psel && penable && pready_reg;
  assign wr        = access && pwrite && !pslverr_reg;
  assign xer_wr    = wr && paddr == ADDR_XER;
  assign dec       = fpdu_decode(pwdata);
  assign start_acc = wr && paddr == ADDR_INSTR && state_reg == ST_IDLE;
  assign fin       = state_reg == ST_WAIT && dif.done;
  assign signed_op = op_reg != OP_UDIV;
  assign neg_q     = signed_op && (opa_reg[63] ^ opb_reg[63]);
  assign neg_r     = signed_op && opa_reg[63];
  // overflow: zero divisor in every mode, 64-bit min/-1 for signed doubleword, word min/-1 for short divide
  assign short_min = op_reg == OP_SHORT && opa_reg == fpdu_sext32(MIN32) && opb_reg == ONES64;
  assign ovf = (opb_reg == 64'h0)
            || (op_reg == OP_SDIV && opa_reg == MIN64 && opb_reg == ONES64)
            || short_min;
  assign dif.start    = go_reg;
  assign dif.dividend = (signed_op && opa_reg[63]) ? 64'h0 - opa_reg : opa_reg;
  assign dif.divisor  = (signed_op && opb_reg[63]) ? 64'h0 - opb_reg : opb_reg;
  assign q_res        = neg_q ? 64'h0 - dif.quotient : dif.quotient;
  assign r_res        = neg_r ? 64'h0 - dif.remainder : dif.remainder;

  // ****************************************
  // apb answer
  // ****************************************
  always_comb begin
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    prdata_next  = 32'h0;
    if (psel && !penable) begin
      pready_next = 1'b1;
      case (paddr)
        ADDR_INSTR:    prdata_next = instr_reg;
        ADDR_DVD_LO:   prdata_next = dvd_reg[31:0];
        ADDR_DVD_HI:   prdata_next = dvd_reg[63:32];
        ADDR_DVS_LO:   prdata_next = dvs_reg[31:0];
        ADDR_DVS_HI:   prdata_next = dvs_reg[63:32];
        ADDR_RES_LO:   prdata_next = res_reg[31:0];
        ADDR_RES_HI:   prdata_next = res_reg[63:32];
        ADDR_EXT:      prdata_next = ext_reg;
        ADDR_XER:      prdata_next = {29'h0, xer_reg};
        ADDR_CR0:      prdata_next = {28'h0, cr0_reg};
        ADDR_STATUS:   prdata_next = {31'h0, state_reg == ST_WAIT};
        ADDR_IRQ_STAT: prdata_next = {29'h0, stat_reg};
        ADDR_IRQ_MASK: prdata_next = {29'h0, mask_reg};
        default:       pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // registers and divide sequence
  // ****************************************
  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    oe_next    = oe_reg;
    rc_next    = rc_reg;
    go_next    = 1'b0;
    instr_next = instr_reg;
    dvd_next   = dvd_reg;
    dvs_next   = dvs_reg;
    opa_next   = opa_reg;
    opb_next   = opb_reg;
    res_next   = res_reg;
    ext_next   = ext_reg;
    xer_next   = xer_reg;
    cr0_next   = cr0_reg;
    mask_next  = mask_reg;
    irq_set    = 3'h0;
    w1c        = 3'h0;
    if (wr) begin
      case (paddr)
        ADDR_DVD_LO:   dvd_next[31:0]  = pwdata;
        ADDR_DVD_HI:   dvd_next[63:32] = pwdata;
        ADDR_DVS_LO:   dvs_next[31:0]  = pwdata;
        ADDR_DVS_HI:   dvs_next[63:32] = pwdata;
        ADDR_XER:      xer_next        = pwdata[2:0];
        ADDR_IRQ_STAT: w1c             = pwdata[2:0];
        ADDR_IRQ_MASK: mask_next       = pwdata[2:0];
        default:       ;
      endcase
    end
    unique case (state_reg)
      ST_IDLE: if (start_acc) begin
        instr_next = pwdata;
        if (dec == OP_NONE || (dec != OP_SHORT && !IMPL64)) begin
          irq_set[IRQ_ILL] = 1'b1;
        end else begin
          state_next = ST_WAIT;
          go_next    = 1'b1;
          op_next    = dec;
          oe_next    = pwdata[OE_BIT];
          rc_next    = pwdata[RC_BIT];
          opa_next   = (dec == OP_SHORT) ? fpdu_sext32(dvd_reg[31:0]) : dvd_reg;
          opb_next   = (dec == OP_SHORT) ? fpdu_sext32(dvs_reg[31:0]) : dvs_reg;
        end
      end
      ST_WAIT: if (dif.done) begin
        state_next        = ST_IDLE;
        // magnitude path would give +2**31 here; the word minimum is wanted
        res_next          = short_min ? fpdu_sext32(MIN32) : q_res;
        irq_set[IRQ_DONE] = 1'b1;
        irq_set[IRQ_OVF]  = ovf;
        if (op_reg == OP_SHORT) begin
          ext_next = r_res[31:0];
        end
        // carry is never touched; sticky set wins over a software clear
        if (oe_reg) begin
          xer_next[XER_OV] = ovf;
          xer_next[XER_SO] = xer_next[XER_SO] | ovf;
        end
        if (rc_reg) begin
          cr0_next = {q_res[63], !q_res[63] && q_res != 64'h0,
                      q_res == 64'h0, xer_next[XER_SO]};
        end
      end
    endcase
    stat_next = (stat_reg & ~w1c) | irq_set;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_NONE;
      oe_reg    <= 1'b0;
      rc_reg    <= 1'b0;
      go_reg    <= 1'b0;
      instr_reg <= 32'h0;
      dvd_reg   <= 64'h0;
      dvs_reg   <= 64'h0;
      opa_reg   <= 64'h0;
      opb_reg   <= 64'h0;
      res_reg   <= 64'h0;
      ext_reg   <= 32'h0;
      xer_reg   <= XER_RST;
      cr0_reg   <= CR0_RST;
      stat_reg  <= IRQ_RST;
      mask_reg  <= IRQ_RST;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      oe_reg    <= oe_next;
      rc_reg    <= rc_next;
      go_reg    <= go_next;
      instr_reg <= instr_next;
      dvd_reg   <= dvd_next;
      dvs_reg   <= dvs_next;
      opa_reg   <= opa_next;
      opb_reg   <= opb_next;
      res_reg   <= res_next;
      ext_reg   <= ext_next;
      xer_reg   <= xer_next;
      cr0_reg   <= cr0_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      irq_reg   <= irq_next;
    end
  end

  assign irq = irq_reg;

  // ****************************************
  // checks
  // ****************************************
  a_decode_ops: assert property (@(posedge pclk) disable iff (!presetn)
    (start_acc && dec != OP_NONE && (IMPL64 || dec == OP_SHORT)) |=>
    (state_reg == ST_WAIT && op_reg == $past(dec) && go_reg) ##66 (state_reg == ST_IDLE))
    else $error("divide not launched or not finished in time");

  a_illegal_dword: assert property (@(posedge pclk) disable iff (!presetn)
    (start_acc && (dec == OP_SDIV || dec == OP_UDIV) && !IMPL64) |=>
    (stat_reg[IRQ_ILL] && state_reg == ST_IDLE))
    else $error("doubleword divide not refused");

  a_sdiv_value: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && op_reg == OP_SDIV && !ovf) |=>
    res_reg == $past($signed(opa_reg) / $signed(opb_reg)))
    else $error("signed quotient wrong");

  a_udiv_value: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && op_reg == OP_UDIV && !ovf) |=> res_reg == $past(opa_reg / opb_reg))
    else $error("unsigned quotient wrong");

  a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && oe_reg && ovf) |=> (xer_reg[XER_OV] && xer_reg[XER_SO] && stat_reg[IRQ_OVF]))
    else $error("excess flags not set on overflow");

  a_xer_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && !oe_reg && !xer_wr) |=> $stable(xer_reg))
    else $error("exception flags changed with trap disabled");

  a_carry_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && !xer_wr) |=> xer_reg[XER_CA] == $past(xer_reg[XER_CA]))
    else $error("carry flag changed by divide");

  a_cr_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && !rc_reg) |=> $stable(cr0_reg))
    else $error("condition field changed without record");

  a_cr_signed: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && rc_reg && !ovf) |=> (cr0_reg[3] == res_reg[63] && cr0_reg[1] == (res_reg == 64'h0)))
    else $error("condition field does not follow result");

  a_short_min: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && op_reg == OP_SHORT && opa_reg == fpdu_sext32(MIN32) && opb_reg == ONES64) |=>
    (ext_reg == 32'h0 && res_reg == fpdu_sext32(MIN32)))
    else $error("short min by minus one wrong");

  a_short_rem: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && op_reg == OP_SHORT && !ovf) |=>
    (ext_reg == 32'h0 || ext_reg[31] == $past(opa_reg[63])))
    else $error("remainder sign differs from dividend");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no ready after setup cycle");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr > ADDR_IRQ_MASK) |=> (pslverr && prdata == 32'h0))
    else $error("unmapped address not refused");

  a_done_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    fin |=> stat_reg[IRQ_DONE])
    else $error("done event lost");

  a_illegal_op: assert property (@(posedge pclk) disable iff (!presetn)
    (start_acc && dec == OP_NONE) |=> (stat_reg[IRQ_ILL] && state_reg == ST_IDLE))
    else $error("unknown opcode not refused");

  a_short_sext: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && op_reg == OP_SHORT && !ovf) |=> res_reg == fpdu_sext32(res_reg[31:0]))
    else $error("short quotient not sign extended");

  a_sdiv_excess: assert property (@(posedge pclk) disable iff (!presetn)
    (fin && op_reg == OP_SDIV && oe_reg && ovf) |=> (xer_reg[XER_OV] && xer_reg[XER_SO]))
    else $error("signed overflow not flagged");

endmodule : fpdu_top
`default_nettype wire

// [fpdu_pipe_model.sv]
// fpdu_pipe_model.sv: apb master standing in for the processor pipeline
// assumes a slave on pclk that answers with pready
`default_nettype none
module fpdu_pipe_model (
  // clock
  input  wire logic        pclk,
  // apb master
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
  end

  // ****************************************
  // one transfer; released lines show inverted values
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until ready is seen at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : fpdu_pipe_model
`default_nettype wire

// [fpdu_top_tb.sv]
// fpdu_top_tb.sv: self-checking bench of the divide unit over apb
// assumes fpdu_pkg, fpdu_top and fpdu_pipe_model are compiled first
`default_nettype none
module fpdu_top_tb
  import fpdu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        irq32;
  int          bad_count;
  int          cmp_count;

  always #2 pclk = ~pclk;

  fpdu_top #(.IMPL64(1'b1)) fpdu_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq)
  );

  // 32-bit build on the same bus: doubleword opcodes must be refused
  fpdu_top #(.IMPL64(1'b0)) fpdu_top32_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .irq(irq32)
  );

  fpdu_pipe_model fpdu_pipe_model_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] ins(input logic [8:0] xo, input logic oe, input logic rec);
    return {6'h1F, 15'h0000, oe, xo, rec};
  endfunction : ins

  task automatic fail(input string msg);
    $display("unexpected at %0t: %s", $time, msg);
    bad_count++;
  endtask : fail

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    fpdu_pipe_model_inst.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
    logic [31:0] q;
    logic        e;
    fpdu_pipe_model_inst.xfer(1'b0, a, 32'h00000000, q, e);
    cmp_count++;
    if (q !== exp || e !== err) begin
      $display("unexpected at %0t: addr %h got %h/%b want %h/%b", $time, a, q, e, exp, err);
      bad_count++;
    end
  endtask : chk

  task automatic chk_res(input logic [63:0] exp);
    chk(ADDR_RES_LO, exp[31:0]);
    chk(ADDR_RES_HI, exp[63:32]);
  endtask : chk_res

  task automatic chk_irq(input logic exp);
    @(negedge pclk);
    cmp_count++;
    if (irq !== exp) fail("irq level");
  endtask : chk_irq

  task automatic run(input logic [63:0] dvd, input logic [63:0] dvs, input logic [31:0] w);
    logic [31:0] q;
    logic        e;
    int          n;
    wr(ADDR_DVD_LO, dvd[31:0]);
    wr(ADDR_DVD_HI, dvd[63:32]);
    wr(ADDR_DVS_LO, dvs[31:0]);
    wr(ADDR_DVS_HI, dvs[63:32]);
    wr(ADDR_INSTR, w);
    n = 0;
    do begin
      fpdu_pipe_model_inst.xfer(1'b0, ADDR_STATUS, 32'h00000000, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    if (n >= 40) fail("divide never finished");
  endtask : run

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #200000;
    fail("watchdog expired");
    stop_test();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(ADDR_XER, 32'h0);
    chk(ADDR_CR0, 32'h0);
    chk(ADDR_IRQ_STAT, 32'h0);
    chk(8'h3C, 32'h0, 1'b1);
    wr(ADDR_IRQ_MASK, 32'h0);
    run(64'hFFFFFFFFFFFFFFF9, 64'h2, ins(9'h1E9, 1'b1, 1'b1));
    chk_res(64'hFFFFFFFFFFFFFFFD);
    chk(ADDR_CR0, 32'h8);
    chk(ADDR_XER, 32'h0);
    run(64'hFFFFFFFFFFFFFFFE, ONES64, ins(9'h1C9, 1'b0, 1'b1));
    chk_res(64'h0);
    chk(ADDR_CR0, 32'h2);
    run(ONES64, 64'h1, ins(9'h1C9, 1'b0, 1'b1));
    chk(ADDR_CR0, 32'h8);
    run(64'h5, 64'h0, ins(9'h1C9, 1'b1, 1'b0));
    chk(ADDR_XER, 32'h6);
    chk(ADDR_CR0, 32'h8);
    chk(ADDR_IRQ_STAT, 32'h5);
    chk_irq(1'b0);
    wr(ADDR_IRQ_MASK, 32'h4);
    chk_irq(1'b1);
    wr(ADDR_IRQ_STAT, 32'h7);
    chk(ADDR_IRQ_STAT, 32'h0);
    chk_irq(1'b0);
    run(64'h1, 64'h1, ins(9'h1E9, 1'b0, 1'b0));
    chk_res(64'h1);
    chk(ADDR_XER, 32'h6);
    chk(ADDR_CR0, 32'h8);
    wr(ADDR_IRQ_MASK, 32'h2);
    chk_irq(1'b0);
    cmp_count++;
    if (irq32 !== 1'b1) fail("doubleword divide not refused");
    wr(ADDR_XER, 32'h7);
    run(64'h12345678FFFFFFF9, 64'h2, ins(9'h16B, 1'b1, 1'b1));
    chk_res(64'hFFFFFFFFFFFFFFFD);
    chk(ADDR_EXT, 32'hFFFFFFFF);
    chk(ADDR_CR0, 32'h9);
    chk(ADDR_XER, 32'h5);
    run(64'h80000000, 64'hFFFFFFFF, ins(9'h16B, 1'b1, 1'b0));
    chk_res(64'hFFFFFFFF80000000);
    chk(ADDR_EXT, 32'h0);
    chk(ADDR_XER, 32'h7);
    wr(ADDR_XER, 32'h1);
    run(64'h80000000, 64'hFFFFFFFF, ins(9'h16B, 1'b0, 1'b0));
    chk(ADDR_XER, 32'h1);
    run(64'h1, 64'h2, ins(9'h16B, 1'b0, 1'b1));
    chk_res(64'h0);
    chk(ADDR_EXT, 32'h1);
    chk(ADDR_CR0, 32'h2);
    wr(ADDR_IRQ_STAT, 32'h7);
    run(64'h7, 64'h7, ins(9'h14B, 1'b0, 1'b0));
    chk(ADDR_IRQ_STAT, 32'h2);
    chk_res(64'h0);
    run(MIN64, ONES64, ins(9'h1E9, 1'b1, 1'b0));
    chk(ADDR_XER, 32'h7);
    chk(ADDR_IRQ_STAT, 32'h7);
    stop_test();
  end
endmodule : fpdu_top_tb
`default_nettype wire
